/* File: bench/card_socket_status_mask_regs_tb.sv */
/* bench: table of register accesses, then event cases.
   assumes design and card model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module card_socket_status_mask_regs_tb;
  logic clock, resetn, reg_req, reg_wr, reg_ack, irq, insert, sts, pwr, clk_en, cb_sel;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, got;
  logic [3:0] volt, iv;
  logic d1, d2, stp, rdy, busy, done, cb;
  int bad_count, tests_run, cyc;
  logic [72:0] rows [9]; // wr, addr, wdata, expected read
  ////////////////////////////////////////////////////////////////
  cssr_socket_status dut (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .detect_pin_one(d1), .detect_pin_two(d2),
    .card_status_pin(stp), .ready_pin(rdy), .socket_power_on(pwr), .ident_busy(busy),
    .ident_done(done), .ident_cardbus(cb), .ident_volt(iv), .status_change_interrupt(irq));
  cssr_card_model card (.clock(clock), .resetn(resetn), .insert(insert), .sts_level(sts),
    .volt(volt), .detect_pin_one(d1), .detect_pin_two(d2), .card_status_pin(stp),
    .ready_pin(rdy), .ident_busy(busy), .ident_done(done), .ident_cardbus(cb),
    .ident_volt(iv), .cardbus(cb_sel));
  ////////////////////////////////////////////////////////////////
  // clock, and a ceiling far above the run's roughly 124 cycles
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_word
  task automatic check_bit(input string what, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit
  // one-cycle request at a falling edge; the registered answer stands
  // only one cycle after the taking edge, so it is read at the next fall
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    reg_req = 1'b1;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    q = reg_rdata;
    check_bit("ack", 1'b1, reg_ack);
    reg_req = 1'b0;
    @(negedge clock);
  endtask : bus
  ////////////////////////////////////////////////////////////////
  initial begin
    {reg_req, reg_wr, reg_addr, reg_wdata, resetn, insert, sts, pwr, cb_sel} = '0;
    clk_en = 1'b1;
    volt = 4'hA;
    rows = '{{9'h004, 32'h0, 32'h0}, {9'h008, 32'h0, 32'h30000006},
      {9'h000, 32'h0, 32'h0}, {9'h104, 32'hFFFFFFFF, 32'h0},
      {9'h004, 32'h0, 32'hF}, {9'h108, 32'hFFFFFFFF, 32'h0},
      {9'h008, 32'h0, 32'h30000006}, {9'h010, 32'h0, 32'h0}, {9'h104, 32'h0, 32'h0}};
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    foreach (rows[i]) begin
      bus(rows[i][72], rows[i][71:64], rows[i][63:32], got);
      if (!rows[i][72]) check_word("row", rows[i][31:0], got);
    end
    // status pin rises with its enable off, then falls
    sts = 1'b1;
    repeat (3) @(negedge clock);
    check_bit("irq masked", 1'b0, irq);
    bus(1'b0, 8'h00, 32'h0, got);
    check_word("sts event", 32'h1, got);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("sts level", 32'h30000007, got);
    bus(1'b1, 8'h04, 32'h1, got);
    @(negedge clock);
    check_bit("irq on", 1'b1, irq);
    bus(1'b1, 8'h00, 32'h1, got);
    @(negedge clock);
    check_bit("irq cleared", 1'b0, irq);
    sts = 1'b0;
    repeat (3) @(negedge clock);
    check_bit("falling edge", 1'b1, irq);
    // socket power comes up with only power events enabled
    bus(1'b1, 8'h04, 32'h8, got);
    bus(1'b1, 8'h00, 32'h1, got);
    pwr = 1'b1;
    repeat (3) @(negedge clock);
    check_bit("power irq", 1'b1, irq);
    bus(1'b1, 8'h00, 32'h8, got);
    @(negedge clock);
    check_bit("power cleared", 1'b0, irq);
    // insertion with detect field 11; only legal codes are written
    bus(1'b1, 8'h04, 32'h6, got);
    insert = 1'b1;
    // read once the probe has already moved the pins
    repeat (2) @(negedge clock);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("view while probing", 32'h3000000E, got);
    repeat (12) @(negedge clock);
    check_bit("insert irq", 1'b1, irq);
    bus(1'b0, 8'h00, 32'h0, got);
    check_word("detect events", 32'h6, got);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("card fields", 32'h30002858, got);
    volt = 4'h5;
    bus(1'b1, 8'h04, 32'h0, got);
    @(negedge clock);
    check_bit("detect masked", 1'b0, irq);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("fields held", 32'h30002858, got);
    bus(1'b1, 8'h0C, 32'h88002800, got);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("forced view", 32'h88002858, got);
    // enable low: a status pulse that comes and goes must be missed
    clk_en = 1'b0;
    sts = 1'b1;
    repeat (3) @(negedge clock);
    sts = 1'b0;
    repeat (3) @(negedge clock);
    clk_en = 1'b1;
    bus(1'b0, 8'h00, 32'h0, got);
    check_word("frozen events", 32'h6, got);
    // remove, then seat a CardBus card: status events on rising edges only
    insert = 1'b0;
    repeat (2) @(negedge clock);
    cb_sel = 1'b1;
    insert = 1'b1;
    repeat (12) @(negedge clock);
    bus(1'b1, 8'h00, 32'hF, got);
    bus(1'b1, 8'h04, 32'h1, got);
    sts = 1'b1;
    repeat (3) @(negedge clock);
    check_bit("cardbus rise", 1'b1, irq);
    bus(1'b1, 8'h00, 32'h1, got);
    sts = 1'b0;
    repeat (3) @(negedge clock);
    check_bit("cardbus fall", 1'b0, irq);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("cardbus fields", 32'h88001468, got);
    // reset in mid-run with an interrupt pending
    sts = 1'b1;
    repeat (3) @(negedge clock);
    insert = 1'b0;
    resetn = 1'b0;
    @(negedge clock);
    check_bit("reset irq", 1'b0, irq);
    @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    bus(1'b0, 8'h08, 32'h0, got);
    check_word("view after reset", 32'h3000000F, got);
    bus(1'b0, 8'h00, 32'h0, got);
    check_word("events after reset", 32'h0, got);
    wrap_up();
  end
endmodule : card_socket_status_mask_regs_tb
`default_nettype wire

/* File: bench/cssr_card_model.sv */
/* inserted card: detect, status and ready pins, identification result.
   assumes insert and levels change off the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module cssr_card_model (
  input wire logic clock, // bus clock
  input wire logic resetn, // async reset, active low
  input wire logic insert, // card seated
  input wire logic sts_level, // status-change level
  input wire logic [3:0] volt, // voltages the card takes
  input wire logic cardbus, // card type the bench picks
  output logic detect_pin_one, // low when seated
  output logic detect_pin_two, // low when seated
  output logic card_status_pin, // status-change pin
  output logic ready_pin, // high once identified
  output logic ident_busy, // probing the card
  output logic ident_done, // one-cycle result pulse
  output logic ident_cardbus, // result card type
  output logic [3:0] ident_volt // result voltages
);
  logic [2:0] cnt;
  logic seated;
  // probing runs from the insert edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 3'h0;
      seated <= 1'b0;
    end else begin
      seated <= insert;
      if (insert && !seated) begin
        cnt <= 3'h7;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
  // pins wiggle while probed, so hidden moves really happen
  assign detect_pin_one = (cnt == 3'h0) ? !seated : cnt[0];
  assign detect_pin_two = (cnt == 3'h0) ? !seated : !cnt[0];
  assign card_status_pin = sts_level;
  assign ready_pin = seated && (cnt == 3'h0);
  assign ident_busy = cnt > 3'h1;
  assign ident_done = cnt == 3'h1;
  assign ident_cardbus = cardbus;
  assign ident_volt = volt;
endmodule : cssr_card_model
`default_nettype wire

/* File: design/cssr_cfg.svh */
/*
  Register offsets, field positions and reset values of the socket
  status and event-enable bank.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef CSSR_CFG_SVH
`define CSSR_CFG_SVH

// register offsets inside the socket window
`define CSSR_OFF_EVENT 8'h00
`define CSSR_OFF_ENABLE 8'h04
`define CSSR_OFF_VIEW 8'h08
`define CSSR_OFF_FORCE 8'h0C

// event and enable field layout, bits 3..0
`define CSSR_EV_W 4
`define CSSR_EV_STS 0
`define CSSR_EV_DET1 1
`define CSSR_EV_DET2 2
`define CSSR_EV_PWR 3

// condition view field positions
`define CSSR_B_READY 6
`define CSSR_B_CB 5
`define CSSR_B_16 4
`define CSSR_B_CARDV 10
`define CSSR_B_VIDEO 27
`define CSSR_B_SOCK 28
`define CSSR_B_RSVD_LO 14
`define CSSR_RSVD_W 13

// reset values
`define CSSR_SOCK_RST 4'h3
`define CSSR_ENABLE_RST 4'h0
`define CSSR_WORD_ZERO 32'h00000000

`endif

/* File: design/cssr_pkg.sv */
/*
  Types of the socket status and event-enable bank.
  Assumes the constants header sits beside it.
*/
`include "cssr_cfg.svh"

package cssr_pkg;

  // whole state of the bank, registered in one process
  typedef struct packed {
    logic primed;
    logic [3:0] enable;
    logic [3:0] event_bits;
    logic [3:0] sock_cap;
    logic video;
    logic [3:0] card_volt;
    logic cb_card;
    logic bit16_card;
    logic det1;
    logic det2;
    logic sts_prev;
    logic pwr;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } cssr_state_t;

endpackage : cssr_pkg

/* File: design/cssr_socket_status.sv */
/*
  Socket event, event-enable and condition-view registers of one card
  socket, with the card status change interrupt.
  Assumes a register port synchronous to clock, card pins already
  synchronous, and an identification engine that reports busy/done.
*/
// Behaviour
// - enable bits choose which events interrupt
// - events record regardless of enable bits
// - enable bits 31..4 read zero, 3..0 RW
// - enable bit 3 gates power-cycle events
// - detect enable field 00 off, 11 on
// - enable bit 0 gates status pin events
// - condition view shows forced values
// - card fields captured at identification; voltage also set by a force write
// - identification pin moves hide from detect bits
// - bits 31,30 zero unless forced
// - bits 29,28 one unless forced
// - bit 27 reports video port support
// - view bits 26..14 read zero
// - bits 13..10 show card voltage support
// - view read-only, reset 3000_00XX
// - event sets on change, write one clears
// - CardBus rising edge, 16-bit both edges
// - view bit 0 mirrors status pin
// - view bit 3 shows socket powered
`timescale 1ns/1ps
`default_nettype none
`include "cssr_cfg.svh"

module cssr_socket_status
  import cssr_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter bit VIDEO_RST = 1'b0
) (
  input wire logic clock, // 100 MHz bus clock
  input wire logic resetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic reg_req, // register access, one cycle
  input wire logic reg_wr, // 1 write, 0 read
  input wire logic [7:0] reg_addr, // byte offset in window
  input wire logic [DATA_W-1:0] reg_wdata, // write data
  output logic [DATA_W-1:0] reg_rdata, // read data, with ack
  output logic reg_ack, // answer pulse
  input wire logic detect_pin_one, // card detect pin 1 level
  input wire logic detect_pin_two, // card detect pin 2 level
  input wire logic card_status_pin, // status-change pin level
  input wire logic ready_pin, // ready/interrupt pin level
  input wire logic socket_power_on, // socket supply is up
  input wire logic ident_busy, // identification running
  input wire logic ident_done, // identification result pulse
  input wire logic ident_cardbus, // result: CardBus card
  input wire logic [3:0] ident_volt, // result: {Y.Y,X.X,3.3,5} ok
  output logic status_change_interrupt // card status change irq
);

  if (DATA_W != 32) begin : g_bad_width
    $error("cssr_socket_status: DATA_W must be 32");
  end

  ////////////////////////////////////////////////////////////////////
  // decode and event sources

  cssr_state_t st;
  cssr_state_t next_st;
  logic wr_event;
  logic wr_enable;
  logic wr_force;
  logic det_live;
  logic [3:0] force_vec;
  logic [3:0] clear_vec;
  logic [3:0] set_vec;
  logic sts_edge;

  // strobes per register; view is read-only, writes ignored
  assign wr_event = reg_req & reg_wr & (reg_addr == `CSSR_OFF_EVENT);
  assign wr_enable = reg_req & reg_wr & (reg_addr == `CSSR_OFF_ENABLE);
  assign wr_force = reg_req & reg_wr & (reg_addr == `CSSR_OFF_FORCE);
  assign force_vec = wr_force ? reg_wdata[`CSSR_EV_W-1:0] : `CSSR_ENABLE_RST;
  assign clear_vec = wr_event ? reg_wdata[`CSSR_EV_W-1:0] : `CSSR_ENABLE_RST;

  // detect bits only follow the pins outside identification
  assign det_live = st.primed & ~ident_busy;

  // CardBus cards flag rising edges only, 16-bit cards both
  assign sts_edge = st.cb_card ? (card_status_pin & ~st.sts_prev)
                               : (card_status_pin ^ st.sts_prev);

  // sources are recorded whatever the enable bits say
  assign set_vec[`CSSR_EV_STS] = (st.primed & sts_edge)
                               | force_vec[`CSSR_EV_STS];
  assign set_vec[`CSSR_EV_DET1] = (det_live & (detect_pin_one ^ st.det1))
                                | force_vec[`CSSR_EV_DET1];
  assign set_vec[`CSSR_EV_DET2] = (det_live & (detect_pin_two ^ st.det2))
                                | force_vec[`CSSR_EV_DET2];
  assign set_vec[`CSSR_EV_PWR] = (st.primed & (socket_power_on ^ st.pwr))
                               | force_vec[`CSSR_EV_PWR];

  ////////////////////////////////////////////////////////////////////
  // condition view word

  // view is assembled at read time so status and ready pin bits are current
  function automatic logic [31:0] view_word(
    input cssr_state_t s,
    input logic sts_pin,
    input logic rdy_pin
  );
    logic [31:0] w;
    w = `CSSR_WORD_ZERO;
    w[`CSSR_B_SOCK +: 4] = s.sock_cap;
    w[`CSSR_B_VIDEO] = s.video;
    w[`CSSR_B_CARDV +: 4] = s.card_volt;
    w[`CSSR_B_READY] = rdy_pin;
    w[`CSSR_B_CB] = s.cb_card;
    w[`CSSR_B_16] = s.bit16_card;
    w[`CSSR_EV_PWR] = s.pwr;
    w[`CSSR_EV_DET2] = s.det2;
    w[`CSSR_EV_DET1] = s.det1;
    w[`CSSR_EV_STS] = sts_pin;
    return w;
  endfunction : view_word

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // first enabled cycle after reset just samples the pins, so a
    // card already seated at power-up raises no spurious event
    next_st.primed = 1'b1;
    next_st.sts_prev = card_status_pin;
    next_st.pwr = socket_power_on;
    if (!st.primed || !ident_busy) begin
      next_st.det1 = detect_pin_one;
      next_st.det2 = detect_pin_two;
    end
    // set wins over a write-one clear in the same cycle
    next_st.event_bits = (st.event_bits & ~clear_vec) | set_vec;
    if (wr_enable) begin
      next_st.enable = reg_wdata[`CSSR_EV_W-1:0];
    end
    // card fields move only on identification or a forced write
    if (ident_done) begin
      next_st.card_volt = ident_volt;
      next_st.cb_card = ident_cardbus;
      next_st.bit16_card = ~ident_cardbus;
    end
    if (wr_force) begin
      next_st.card_volt = reg_wdata[`CSSR_B_CARDV +: 4];
      next_st.video = reg_wdata[`CSSR_B_VIDEO];
      next_st.sock_cap = reg_wdata[`CSSR_B_SOCK +: 4];
    end
    // each enable bit gates its own event bit
    next_st.irq = |(next_st.event_bits & next_st.enable);
    // every request taken while clk_en is high gets one answer the next cycle
    next_st.ack = reg_req;
    next_st.rdata = `CSSR_WORD_ZERO;
    if (reg_req && !reg_wr) begin
      unique case (reg_addr)
        `CSSR_OFF_EVENT: next_st.rdata[`CSSR_EV_W-1:0] = st.event_bits;
        `CSSR_OFF_ENABLE: next_st.rdata[`CSSR_EV_W-1:0] = st.enable;
        `CSSR_OFF_VIEW: next_st.rdata = view_word(st, card_status_pin,
                                                  ready_pin);
        default: next_st.rdata = `CSSR_WORD_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // reset to documented defaults; clk_en freezes everything
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.sock_cap <= `CSSR_SOCK_RST;
      st.video <= VIDEO_RST;
      st.det1 <= 1'b1;
      st.det2 <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_ack = st.ack;
  assign status_change_interrupt = st.irq;

  ////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb_main @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_read(logic [7:0] off);
    clk_en && reg_req && !reg_wr && reg_addr == off;
  endsequence

  sequence s_answer;
    reg_ack;
  endsequence

  property p_mask_rsvd;
    s_read(`CSSR_OFF_ENABLE) |=> reg_rdata[31:4] == 28'h0000000
      && reg_rdata[3:0] == $past(st.enable);
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd)
    else $error("enable register read wrong");

  property p_view_rsvd;
    s_read(`CSSR_OFF_VIEW) ##1 s_answer |-> reg_rdata[26:14] == 13'h0000
      && reg_rdata[29:28] == $past(st.sock_cap[1:0]);
  endproperty
  a_view_rsvd: assert property (p_view_rsvd)
    else $error("view reserved or socket bits wrong");

  property p_view_status;
    s_read(`CSSR_OFF_VIEW) |=> reg_rdata[0] == $past(card_status_pin)
      && reg_rdata[3] == $past(st.pwr);
  endproperty
  a_view_status: assert property (p_view_status)
    else $error("view pin bits wrong");

  property p_irq_tracks;
    status_change_interrupt == (|(st.event_bits & st.enable));
  endproperty
  a_irq_tracks: assert property (p_irq_tracks)
    else $error("interrupt not tied to enabled events");

  property p_record_unmasked;
    clk_en && st.primed && !ident_busy && detect_pin_one != st.det1
      |=> st.event_bits[1];
  endproperty
  a_record_unmasked: assert property (p_record_unmasked)
    else $error("detect change not recorded");

  property p_ident_hold;
    clk_en && st.primed && ident_busy |=> $stable(st.det1) && $stable(st.det2);
  endproperty
  a_ident_hold: assert property (p_ident_hold)
    else $error("detect bit moved during identification");

  property p_card_hold;
    clk_en && !ident_done && !wr_force |=> $stable(st.card_volt)
      && $stable(st.cb_card);
  endproperty
  a_card_hold: assert property (p_card_hold)
    else $error("card fields changed outside identification");

  property p_cb_fall;
    clk_en && st.primed && st.cb_card && st.sts_prev && !card_status_pin
      && !st.event_bits[0] && !force_vec[0] |=> !st.event_bits[0];
  endproperty
  a_cb_fall: assert property (p_cb_fall)
    else $error("CardBus falling edge set status event");

  property p_w1c;
    clk_en && wr_event && reg_wdata[3] && !set_vec[3] |=> !st.event_bits[3];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear event");

  property p_pwr_gate;
    !st.enable[3] && st.event_bits[3:0] == 4'h8 |-> !status_change_interrupt;
  endproperty
  a_pwr_gate: assert property (p_pwr_gate)
    else $error("masked power event raised interrupt");

  property p_ack;
    clk_en && reg_req |=> s_answer ##1 (!reg_ack || $past(reg_req));
  endproperty
  a_ack: assert property (p_ack)
    else $error("request not answered next cycle");

  property p_enable_write;
    clk_en && wr_enable |=> st.enable == $past(reg_wdata[3:0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write not taken");

  property p_force_set;
    clk_en && wr_force |=> (st.event_bits & $past(reg_wdata[3:0]))
      == $past(reg_wdata[3:0]);
  endproperty
  a_force_set: assert property (p_force_set)
    else $error("forced event not recorded");

  property p_both_edges;
    clk_en && st.primed && !st.cb_card && card_status_pin != st.sts_prev
      |=> st.event_bits[0];
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("16-bit status edge not recorded");

  property p_probe_quiet;
    clk_en && st.primed && ident_busy && !force_vec[1] && !st.event_bits[1]
      |=> !st.event_bits[1];
  endproperty
  a_probe_quiet: assert property (p_probe_quiet)
    else $error("detect event recorded during identification");

  property p_view_card;
    s_read(`CSSR_OFF_VIEW) |=> reg_rdata[13:10] == $past(st.card_volt)
      && reg_rdata[27] == $past(st.video);
  endproperty
  a_view_card: assert property (p_view_card)
    else $error("view card or video bits wrong");

endmodule : cssr_socket_status

`default_nettype wire
